// File: acc_pkg.sv
// constants for the two-channel comparator control block
// assumes a 32-bit axi4-lite register bus and one 40 MHz clock
package acc_pkg;
    localparam int unsigned ACC_NUM          = 2;
    localparam int unsigned ACC_ADDR_W       = 6;
    // register byte offsets (one word each)
    localparam logic [5:0]  ACC_OFF_CTRL0_C1 = 6'h00;
    localparam logic [5:0]  ACC_OFF_CTRL1_C1 = 6'h04;
    localparam logic [5:0]  ACC_OFF_CTRL0_C2 = 6'h08;
    localparam logic [5:0]  ACC_OFF_CTRL1_C2 = 6'h0C;
    localparam logic [5:0]  ACC_OFF_MIRROR   = 6'h10;
    localparam logic [5:0]  ACC_OFF_FLAGS    = 6'h14;
    // control register 0 field positions
    localparam int unsigned ACC_C0_ENABLE    = 7;
    localparam int unsigned ACC_C0_OUTPUT    = 6;
    localparam int unsigned ACC_C0_PIN_OE    = 5;
    localparam int unsigned ACC_C0_INVERT    = 4;
    localparam int unsigned ACC_C0_SPEED     = 2;
    localparam int unsigned ACC_C0_HYST      = 1;
    localparam int unsigned ACC_C0_SYNC      = 0;
    localparam logic [7:0]  ACC_C0_WMASK     = 8'hB7;
    localparam logic [7:0]  ACC_C0_RESET     = 8'h04;
    // control register 1 field positions
    localparam int unsigned ACC_C1_RISE_IE   = 7;
    localparam int unsigned ACC_C1_FALL_IE   = 6;
    localparam int unsigned ACC_C1_PSEL_LO   = 4;
    localparam int unsigned ACC_C1_NSEL_LO   = 0;
    localparam logic [7:0]  ACC_C1_WMASK     = 8'hF3;
    localparam logic [7:0]  ACC_C1_RESET     = 8'h00;
    // positive input select codes
    localparam logic [1:0]  ACC_PSEL_PIN     = 2'h0;
    localparam logic [1:0]  ACC_PSEL_DAC     = 2'h1;
    localparam logic [1:0]  ACC_PSEL_FIXED   = 2'h2;
    localparam logic [1:0]  ACC_PSEL_GROUND  = 2'h3;
    localparam logic [1:0]  ACC_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  ACC_RESP_SLVERR  = 2'h2;
endpackage

// File: acc_top.sv
// control and output logic around two analog comparators, axi4-lite slave
// assumes raw results arrive asynchronously from the analog macro and
// the gated timer clock arrives as an ordinary asynchronous input
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [acc_pkg::ACC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [acc_pkg::ACC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [1:0]                  raw_result,
    input  wire logic [1:0]                  timer_clk_prescaled,
    input  wire logic [1:0]                  pin_direction,
    input  wire logic [1:0]                  port_latch,
    output logic [1:0]                       comparator_power_en,
    output logic [1:0]                       speed_power_select,
    output logic [1:0]                       hysteresis_enable,
    output logic [3:0]                       positive_input_sel_onehot,
    output logic [3:0]                       positive_input_sel_onehot_c2,
    output logic [3:0]                       negative_input_sel_onehot,
    output logic [3:0]                       negative_input_sel_onehot_c2,
    output logic [1:0]                       timer_gate_source,
    output logic [1:0]                       pwm_shutdown_source,
    output logic [1:0]                       pin_out,
    output logic [1:0]                       pin_out_en,
    output logic [1:0]                       comparator_irq_flag
);
    import acc_pkg::*;

    // one-hot route decode, zero when the comparator is off
    function automatic logic [3:0] route_sel(input logic [1:0] sel, input logic en);
        route_sel = en ? (4'h1 << sel) : 4'h0;
    endfunction

    logic [7:0] ctrl0_reg [ACC_NUM];
    logic [7:0] ctrl0_next [ACC_NUM];
    logic [7:0] ctrl1_reg [ACC_NUM];
    logic [7:0] ctrl1_next [ACC_NUM];
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] tclk1_reg;
    logic [1:0] tclk2_reg;
    logic [1:0] tclk3_reg;
    logic [1:0] tcap_reg;
    logic [1:0] tcap_next;
    logic [1:0] rep_reg;
    logic [1:0] rep_next;
    logic [1:0] rep_prev_reg;
    logic [1:0] flag_reg;
    logic [1:0] flag_next;
    logic [1:0] reported;
    logic [1:0] ext_result;
    logic       aw_held_reg;
    logic       aw_held_next;
    logic       w_held_reg;
    logic       w_held_next;
    logic [5:0] awaddr_reg;
    logic [5:0] awaddr_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic       wstrb0_reg;
    logic       wstrb0_next;
    logic       bvalid_next;
    logic [1:0] bresp_next;
    logic       rvalid_next;
    logic [31:0] rdata_next;
    logic [1:0] rresp_next;
    logic       do_write;
    logic [1:0] flag_clear;

    // raw result and timer clock synchronisers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            tclk1_reg <= 2'h0;
            tclk2_reg <= 2'h0;
            tclk3_reg <= 2'h0;
        end
        else
        begin
            sync1_reg <= raw_result;
            sync2_reg <= sync1_reg;
            tclk1_reg <= timer_clk_prescaled;
            tclk2_reg <= tclk1_reg;
            tclk3_reg <= tclk2_reg;
        end
    end

    // reported result, timer-synchronous capture and external result
    always_comb
    begin
        tcap_next = tcap_reg;
        for (int i = 0; i < ACC_NUM; i++)
        begin
            // disabled comparator's raw output reads as low
            reported[i] = (ctrl0_reg[i][ACC_C0_ENABLE] & sync2_reg[i])
                          ^ ctrl0_reg[i][ACC_C0_INVERT];
            rep_next[i] = reported[i];
            if (tclk3_reg[i] && !tclk2_reg[i])
                tcap_next[i] = reported[i];
            ext_result[i] = ctrl0_reg[i][ACC_C0_SYNC] ? tcap_reg[i] : reported[i];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tcap_reg     <= 2'h0;
            rep_reg      <= 2'h0;
            rep_prev_reg <= 2'h0;
        end
        else
        begin
            tcap_reg     <= tcap_next;
            rep_reg      <= rep_next;
            rep_prev_reg <= rep_reg;
        end
    end

    // control outputs toward the analog macro and neighbours
    always_comb
    begin
        for (int i = 0; i < ACC_NUM; i++)
        begin
            comparator_power_en[i] = ctrl0_reg[i][ACC_C0_ENABLE];
            speed_power_select[i]  = ctrl0_reg[i][ACC_C0_SPEED];
            hysteresis_enable[i]   = ctrl0_reg[i][ACC_C0_HYST];
            timer_gate_source[i]   = ext_result[i];
            pwm_shutdown_source[i] = rep_reg[i];
            // override latch when oe set; drive only as output, and with oe set only while enabled
            pin_out[i]    = ctrl0_reg[i][ACC_C0_PIN_OE] ? ext_result[i] : port_latch[i];
            pin_out_en[i] = !pin_direction[i]
                            && (!ctrl0_reg[i][ACC_C0_PIN_OE]
                                || ctrl0_reg[i][ACC_C0_ENABLE]);
        end
        positive_input_sel_onehot    = route_sel(ctrl1_reg[0][5:4], ctrl0_reg[0][7]);
        positive_input_sel_onehot_c2 = route_sel(ctrl1_reg[1][5:4], ctrl0_reg[1][7]);
        negative_input_sel_onehot    = route_sel(ctrl1_reg[0][1:0], ctrl0_reg[0][7]);
        negative_input_sel_onehot_c2 = route_sel(ctrl1_reg[1][1:0], ctrl0_reg[1][7]);
        comparator_irq_flag = flag_reg;
    end

    // edge detection into sticky flags; a new edge beats the clear
    always_comb
    begin
        for (int i = 0; i < ACC_NUM; i++)
        begin
            flag_next[i] = (flag_reg[i] && !flag_clear[i])
                || (rep_reg[i] && !rep_prev_reg[i] && ctrl1_reg[i][ACC_C1_RISE_IE])
                || (!rep_reg[i] && rep_prev_reg[i] && ctrl1_reg[i][ACC_C1_FALL_IE]);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_reg <= 2'h0;
        else
            flag_reg <= flag_next;
    end

    // axi4-lite write path: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb0_next  = wstrb0_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb0_next = s_axi_wstrb[0];
        end
        do_write    = aw_held_reg && w_held_reg;
        bvalid_next = s_axi_bvalid;
        bresp_next  = s_axi_bresp;
        flag_clear  = 2'h0;
        for (int i = 0; i < ACC_NUM; i++)
        begin
            ctrl0_next[i] = ctrl0_reg[i];
            ctrl1_next[i] = ctrl1_reg[i];
        end
        if (do_write)
        begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = ACC_RESP_OKAY;
            case ({awaddr_reg[5:2], 2'h0})
                ACC_OFF_CTRL0_C1, ACC_OFF_CTRL0_C2:
                begin
                    if (wstrb0_reg)
                        ctrl0_next[awaddr_reg[3]] = wdata_reg[7:0] & ACC_C0_WMASK;
                end
                ACC_OFF_CTRL1_C1, ACC_OFF_CTRL1_C2:
                begin
                    if (wstrb0_reg)
                        ctrl1_next[awaddr_reg[3]] = wdata_reg[7:0] & ACC_C1_WMASK;
                end
                ACC_OFF_MIRROR: ; // read-only, write ignored
                ACC_OFF_FLAGS:
                begin
                    if (wstrb0_reg)
                        flag_clear = ~wdata_reg[1:0];
                end
                default: bresp_next = ACC_RESP_SLVERR;
            endcase
        end
        else if (s_axi_bvalid && s_axi_bready)
            bvalid_next = 1'b0;
    end

    // axi4-lite read path, one cycle to rvalid
    always_comb
    begin
        rvalid_next = s_axi_rvalid;
        rdata_next  = s_axi_rdata;
        rresp_next  = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next  = ACC_RESP_OKAY;
            case ({s_axi_araddr[5:2], 2'h0})
                ACC_OFF_CTRL0_C1, ACC_OFF_CTRL0_C2:
                begin
                    rdata_next = {24'h00_0000, ctrl0_reg[s_axi_araddr[3]]};
                    rdata_next[ACC_C0_OUTPUT] = rep_reg[s_axi_araddr[3]];
                end
                ACC_OFF_CTRL1_C1, ACC_OFF_CTRL1_C2:
                    rdata_next = {24'h00_0000, ctrl1_reg[s_axi_araddr[3]]};
                ACC_OFF_MIRROR: rdata_next = {30'h0000_0000, rep_reg};
                ACC_OFF_FLAGS:  rdata_next = {30'h0000_0000, flag_reg};
                default:
                begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = ACC_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            rvalid_next = 1'b0;
    end

    // bus and register state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 6'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb0_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ACC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ACC_RESP_OKAY;
            for (int i = 0; i < ACC_NUM; i++)
            begin
                ctrl0_reg[i] <= ACC_C0_RESET;
                ctrl1_reg[i] <= ACC_C1_RESET;
            end
        end
        else
        begin
            aw_held_reg  <= aw_held_next;
            w_held_reg   <= w_held_next;
            awaddr_reg   <= awaddr_next;
            wdata_reg    <= wdata_next;
            wstrb0_reg   <= wstrb0_next;
            s_axi_bvalid <= bvalid_next;
            s_axi_bresp  <= bresp_next;
            s_axi_rvalid <= rvalid_next;
            s_axi_rdata  <= rdata_next;
            s_axi_rresp  <= rresp_next;
            for (int i = 0; i < ACC_NUM; i++)
            begin
                ctrl0_reg[i] <= ctrl0_next[i];
                ctrl1_reg[i] <= ctrl1_next[i];
            end
        end
    end
endmodule

// File: acc_properties.sv
// checker for the comparator control block
// sees only acc_top ports; bound at the foot of this file
`timescale 1ns/1ps
module acc_properties (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [1:0] pin_direction,
    input wire logic [1:0] comparator_power_en,
    input wire logic [1:0] speed_power_select,
    input wire logic [3:0] positive_input_sel_onehot,
    input wire logic [3:0] negative_input_sel_onehot,
    input wire logic [1:0] pin_out_en,
    input wire logic [1:0] pwm_shutdown_source,
    input wire logic [1:0] comparator_irq_flag
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // input routing and pin driver
    a_inputs_off: assert property (
        !comparator_power_en[0] |-> (positive_input_sel_onehot | negative_input_sel_onehot) == 0)
        else $error("inputs connected while disabled");
    a_pos_onehot: assert property (
        comparator_power_en[0] |-> $onehot(positive_input_sel_onehot))
        else $error("positive select not one-hot");
    a_neg_onehot: assert property (
        comparator_power_en[0] |-> $onehot(negative_input_sel_onehot))
        else $error("negative select not one-hot");
    a_pin_dir_off: assert property (
        (pin_direction & pin_out_en) == 2'h0)
        else $error("pin driven while set as input");
    // flag sets only after a result change, clears only with a write
    a_flag_cause: assert property (
        $rose(comparator_irq_flag[0]) |->
        $past(pwm_shutdown_source[0]) != $past(pwm_shutdown_source[0], 2))
        else $error("flag set without result edge");
    a_flag_clear: assert property (
        $fell(comparator_irq_flag[0]) |-> $rose(s_axi_bvalid))
        else $error("flag cleared without write");
    a_speed_reset: assert property (
        $rose(aresetn) |-> speed_power_select == 2'h3)
        else $error("speed select not normal after reset");
    a_speed_write: assert property (
        $changed(speed_power_select) |-> $rose(s_axi_bvalid))
        else $error("speed select changed without write");
    // bus answers
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_read_cause: assert property (
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
        else $error("read answer without request");
    c_flag: cover property ($rose(comparator_irq_flag[0]));
    c_pin: cover property (pin_out_en[0] && comparator_power_en[0]);
    c_read: cover property ($rose(s_axi_rvalid));
endmodule

bind acc_top acc_properties chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .s_axi_arvalid, .s_axi_arready, .pin_direction, .comparator_power_en,
    .speed_power_select, .positive_input_sel_onehot, .negative_input_sel_onehot,
    .pin_out_en, .pwm_shutdown_source, .comparator_irq_flag);

// File: acc_analog_model.sv
// analog far side: input pins and references of both comparators
// assumes acc_top one-hot selects; levels are set by the bench
`timescale 1ns/1ps
module acc_analog_model (
    input wire logic       aclk,
    input wire logic [3:0] psel_c1,
    input wire logic [3:0] psel_c2,
    input wire logic [3:0] nsel_c1,
    input wire logic [3:0] nsel_c2,
    output logic     [1:0] raw_result
);
    int   lvl_plus [2] = '{0, 0};
    int   lvl_neg [4] = '{0, 0, 0, 0};
    int   lvl_dac = 0;
    int   lvl_fixed = 0;
    logic idle_tgl = 1'b0;

    // compare the selected levels; a floating positive input gives no stable answer, a floating negative one reads lvl_neg[3]
    function automatic logic cmp(input logic [3:0] p, input logic [3:0] n, input int c);
        int vp;
        int vn;
        vp = p[0] ? lvl_plus[c] : p[1] ? lvl_dac : p[2] ? lvl_fixed : 0;
        vn = n[0] ? lvl_neg[0] : n[1] ? lvl_neg[1] : n[2] ? lvl_neg[2] : lvl_neg[3];
        cmp = (p == 4'h0) ? idle_tgl : (vp > vn);
    endfunction

    // result moves off the bench clock edge, like a real analog output
    always @(negedge aclk)
    begin
        idle_tgl <= ~idle_tgl;
        raw_result <= {cmp(psel_c2, nsel_c2, 1), cmp(psel_c1, nsel_c1, 0)};
    end
endmodule

// File: analog_comparator_control_bench.sv
// self-checking bench for acc_top with the analog far-side model
// assumes acc_pkg constants and a 40 MHz clock
`timescale 1ns/1ps
module analog_comparator_control_bench;
    import acc_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic [1:0]  timer_clk_prescaled = 2'h0, pin_direction = 2'h3, port_latch = 2'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, raw_result, comparator_power_en;
    logic [1:0]  speed_power_select, hysteresis_enable, timer_gate_source;
    logic [1:0]  pwm_shutdown_source, pin_out, pin_out_en, comparator_irq_flag;
    logic [31:0] s_axi_rdata;
    logic [3:0]  positive_input_sel_onehot, positive_input_sel_onehot_c2;
    logic [3:0]  negative_input_sel_onehot, negative_input_sel_onehot_c2;
    int          miscompares = 0;
    int          checked = 0;

    acc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .raw_result,
        .timer_clk_prescaled, .pin_direction, .port_latch, .comparator_power_en,
        .speed_power_select, .hysteresis_enable, .positive_input_sel_onehot,
        .positive_input_sel_onehot_c2, .negative_input_sel_onehot,
        .negative_input_sel_onehot_c2, .timer_gate_source, .pwm_shutdown_source,
        .pin_out, .pin_out_en, .comparator_irq_flag);
    acc_analog_model model_u (.aclk, .psel_c1(positive_input_sel_onehot),
        .psel_c2(positive_input_sel_onehot_c2), .nsel_c1(negative_input_sel_onehot),
        .nsel_c2(negative_input_sel_onehot_c2), .raw_result);

    // clock generator
    always #12.5 aclk = ~aclk;

    task automatic wrap_up;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // axi4-lite write: hold each channel until taken, bready until bvalid
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !(n > 0 && s_axi_bvalid); n++)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk(n < 50, 1);
        if (n >= 50)
            wrap_up();
        chk(s_axi_bresp, ACC_RESP_OKAY);
        @(posedge aclk);
    endtask

    // axi4-lite read with expected data and response
    task automatic rdreg(input logic [5:0] a, input logic [31:0] exp,
                         input logic [1:0] er = ACC_RESP_OKAY);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && !(n > 0 && s_axi_rvalid); n++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(n < 50, 1);
        if (n >= 50)
            wrap_up();
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, er);
        @(posedge aclk);
    endtask

    task automatic t_reset;
        rdreg(ACC_OFF_CTRL0_C1, 8'h04);
        rdreg(ACC_OFF_CTRL1_C2, 8'h00);
        // a write without byte lane 0 leaves the register alone
        s_axi_wstrb <= 4'h0;
        wr(ACC_OFF_CTRL0_C1, 8'hFF);
        s_axi_wstrb <= 4'h1;
        rdreg(ACC_OFF_CTRL0_C1, 8'h04);
        wr(ACC_OFF_MIRROR, 8'hFF);
        rdreg(ACC_OFF_MIRROR, 8'h00);
        rdreg(6'h18, 8'h00, ACC_RESP_SLVERR);
        $display("t_reset done");
    endtask

    task automatic t_polarity;
        logic [7:0] c0;
        logic       e;
        model_u.lvl_neg[0] = 50;
        wr(ACC_OFF_CTRL1_C1, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            model_u.lvl_plus[0] = k[0] ? 20 : 80;
            c0 = k[1] ? 8'h90 : 8'h80;
            e = ~k[0] ^ k[1];
            wr(ACC_OFF_CTRL0_C1, c0);
            repeat (4) @(posedge aclk);
            rdreg(ACC_OFF_CTRL0_C1, c0 | {1'b0, e, 6'h0});
            rdreg(ACC_OFF_MIRROR, e);
        end
        $display("t_polarity done");
    endtask

    task automatic t_select;
        model_u.lvl_dac = 90;
        model_u.lvl_fixed = 10;
        model_u.lvl_plus[0] = 80;
        model_u.lvl_neg = '{40, 60, 40, 60};
        wr(ACC_OFF_CTRL0_C1, 8'h84);
        for (int k = 0; k < 4; k++)
        begin
            wr(ACC_OFF_CTRL1_C1, {2'h0, k[1:0], 2'h0, k[1:0]});
            chk(positive_input_sel_onehot, 4'h1 << k);
            chk(negative_input_sel_onehot, 4'h1 << k);
            repeat (4) @(posedge aclk);
            rdreg(ACC_OFF_MIRROR, k < 2);
        end
        wr(ACC_OFF_CTRL0_C1, 8'h04);
        chk(positive_input_sel_onehot | negative_input_sel_onehot, 4'h0);
        $display("t_select done");
    endtask

    task automatic t_pin;
        logic [7:0] cfg [4] = '{8'hA4, 8'h24, 8'h84, 8'hA4};
        logic [3:0] row [4] = '{4'b0011, 4'b0100, 4'b0010, 4'b1001};
        wr(ACC_OFF_CTRL1_C1, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            pin_direction <= {1'b1, row[k][3]};
            port_latch <= {1'b0, row[k][2]};
            wr(ACC_OFF_CTRL0_C1, cfg[k]);
            repeat (4) @(posedge aclk);
            chk(pin_out_en[0], row[k][1]);
            chk(pin_out[0], row[k][0]);
        end
        $display("t_pin done");
    endtask

    task automatic t_flags;
        wr(ACC_OFF_CTRL0_C1, 8'h04);
        wr(ACC_OFF_CTRL1_C1, 8'h80);
        wr(ACC_OFF_CTRL0_C1, 8'h84);
        repeat (4) @(posedge aclk);
        rdreg(ACC_OFF_FLAGS, 8'h01);
        // a zero written to a flag bit clears it, a one keeps it
        wr(ACC_OFF_FLAGS, 8'h02);
        rdreg(ACC_OFF_FLAGS, 8'h00);
        wr(ACC_OFF_CTRL1_C1, 8'h40);
        wr(ACC_OFF_CTRL0_C1, 8'h14);
        wr(ACC_OFF_FLAGS, 8'h02);
        wr(ACC_OFF_CTRL0_C1, 8'h04);
        repeat (4) @(posedge aclk);
        rdreg(ACC_OFF_FLAGS, 8'h01);
        $display("t_flags done");
    endtask

    // comparator 2 in timer-synchronous mode with hysteresis and low power
    task automatic t_sync;
        model_u.lvl_plus[1] = 80;
        wr(ACC_OFF_CTRL1_C2, 8'h00);
        wr(ACC_OFF_CTRL0_C2, 8'h83);
        repeat (4) @(posedge aclk);
        chk({comparator_power_en, speed_power_select, hysteresis_enable}, 6'h26);
        chk({positive_input_sel_onehot_c2, negative_input_sel_onehot_c2}, 8'h11);
        chk(pwm_shutdown_source[1], 1'b1);
        chk(timer_gate_source[1], 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            timer_clk_prescaled <= 2'h2;
            repeat (6) @(posedge aclk);
            chk(timer_gate_source[1], k);
            timer_clk_prescaled <= 2'h0;
            repeat (6) @(posedge aclk);
            chk(timer_gate_source[1], !k);
            model_u.lvl_plus[1] = 20;
            repeat (6) @(posedge aclk);
            chk(pwm_shutdown_source[1], 1'b0);
        end
        $display("t_sync done");
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_polarity();
        t_select();
        t_pin();
        t_flags();
        t_sync();
        wrap_up();
    end
endmodule
